//--- hdl/bit_fifo.sv
// synchronous fifo of flip-flops with valid/ready on both sides
// assumes one clock; flush empties it in one cycle
`timescale 1ns/10ps
`default_nettype none
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire full_w = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty_w = (wr_q == rd_q);
  wire push_w = in_valid && !full_w;
  wire pop_w = out_ready && !empty_w;

  assign in_ready = !full_w;
  assign out_valid = !empty_w;
  assign out_data = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push_w) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push_w);
      rd_q <= rd_q + (AW+1)'(pop_w);
    end
  end
endmodule
`default_nettype wire

//--- hdl/retimer_ctrl_pkg.sv
// constants, register map and carrier types of the retimer channel control
// assumes a byte-wide register port and a 200 MHz core clock
//
// Behaviour
// RULE1: divider override enable selects divider field
// RULE2: divider codes 0..4 mean 1,2,4,8,16
// RULE3: automatic divider follows incoming rate otherwise
// RULE4: pattern select 0 is 9-stage, 2 is 31-stage
// RULE5: generator enable bit activates generator logic
// RULE6: clock-load clear holds reset, set loads
// RULE7: clock gate bit lets generator advance
// RULE8: software follows the fixed generator start order
// RULE9: mux override plus code 4 sends pattern
// RULE10: vco stays locked whatever the mux selects
// RULE11: no signal powers down unless forced on
// RULE12: override bit plus zero pump field disables pump
// RULE13: cap override takes count from cap register
// RULE14: control voltage override uses voltage register value
// RULE15: software preserves earlier override bits when writing
// RULE16: override register resets and clears to zero
// RULE17: software picks ratio 1 for free run
// RULE18: software overrides divider only when free running
// RULE19: mux codes decode mute, slow clock, pattern, clocks, data
// RULE20: default field mutes output while unlocked
// RULE21: taps x9+x5+1 and x31+x28+1, non-zero seed
`default_nettype none
package retimer_ctrl_pkg;
  localparam logic [7:0] ADDR_VCO_CAP = 8'h08;
  localparam logic [7:0] ADDR_OVERRIDE = 8'h09;
  localparam logic [7:0] ADDR_PAT_GATE = 8'h0d;
  localparam logic [7:0] ADDR_SD_FORCE = 8'h14;
  localparam logic [7:0] ADDR_DIV_SEL = 8'h18;
  localparam logic [7:0] ADDR_CP_CTRL = 8'h1b;
  localparam logic [7:0] ADDR_OUT_SEL = 8'h1e;
  localparam logic [7:0] ADDR_CV_SET = 8'h1f;
  localparam logic [7:0] ADDR_PAT_CFG = 8'h30;

  localparam logic [7:0] RST_OVERRIDE = 8'h00;
  localparam logic [7:0] RST_OUT_SEL = 8'he0;
  localparam logic [7:0] RST_OTHER = 8'h00;

  localparam int DIV_LSB = 4;
  localparam int OUT_SEL_LSB = 5;
  localparam int PAT_EN_BIT = 4;
  localparam int PAT_LOAD_BIT = 3;
  localparam int PAT_GATE_BIT = 5;
  localparam int SD_FORCE_ON_BIT = 7;
  localparam int SD_FORCE_OFF_BIT = 6;
  localparam logic [2:0] DIV_MAX_CODE = 3'h4;

  localparam logic [1:0] PAT_SEL_9 = 2'h0;
  localparam logic [1:0] PAT_SEL_31 = 2'h2;
  localparam logic [30:0] PAT_SEED = 31'h7fff_ffff;

  localparam logic [2:0] MUX_RAW = 3'h0;
  localparam logic [2:0] MUX_RETIMED = 3'h1;
  localparam logic [2:0] MUX_ICLK = 3'h2;
  localparam logic [2:0] MUX_QCLK = 3'h3;
  localparam logic [2:0] MUX_PATTERN = 3'h4;
  localparam logic [2:0] MUX_SLOW_CLK = 3'h5;
  localparam logic [2:0] MUX_MUTE = 3'h7;

  localparam int CORE_CLK_MHZ = 200;
  localparam int SLOW_CLK_MHZ = 10;
  localparam int SLOW_HALF_CYC = CORE_CLK_MHZ / (2 * SLOW_CLK_MHZ);
  localparam int FIFO_DEPTH = 32;

  // bit order of the override register, bit 7 first
  typedef struct packed {
    logic cap_ov;
    logic cv_ov;
    logic mux_ov;
    logic qclk_en;
    logic cp_dis;
    logic div_ov;
    logic [1:0] unused;
  } override_t;

  typedef struct packed {
    logic charge_pump_en;
    logic cap_override;
    logic [4:0] cap_count;
    logic cv_override;
    logic [4:0] cv_value;
  } vco_ctrl_t;
endpackage
`default_nettype wire

//--- hdl/retimer_prbs_and_vco_override_ctrl.sv
// one retimer channel: override registers, divider choice, pattern
// generator, slow test clock and output multiplexer
// assumes all inputs synchronous to core_clk; one line bit per accepted cycle
`timescale 1ns/10ps
`default_nettype none
module retimer_prbs_and_vco_override_ctrl #(
  parameter int FIFO_DEPTH = retimer_ctrl_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  input wire logic signal_present,
  input wire logic cdr_locked,
  input wire logic [2:0] rate_div_code,
  input wire logic raw_data_bit,
  input wire logic retimed_data_bit,
  input wire logic vco_in_phase_clock,
  input wire logic vco_quadrature_clock,
  input wire logic line_ready,
  output logic line_bit_q,
  output logic line_mute_q,
  output logic channel_enable_q,
  output logic vco_track_input_q,
  output logic [2:0] div_code_q,
  output logic [4:0] div_ratio_q,
  output retimer_ctrl_pkg::vco_ctrl_t vco_ctrl_q,
  output logic pattern_running_q
);
  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0] cap_q, ovr_q, gate_q, sdf_q, div_q, cp_q, osel_q, cv_q, pcfg_q;
  retimer_ctrl_pkg::override_t ov_w;
  assign ov_w = retimer_ctrl_pkg::override_t'(ovr_q);

  wire wr_cap = reg_wr && (reg_addr == retimer_ctrl_pkg::ADDR_VCO_CAP);
  wire wr_ovr = reg_wr && (reg_addr == retimer_ctrl_pkg::ADDR_OVERRIDE);
  wire wr_gate = reg_wr && (reg_addr == retimer_ctrl_pkg::ADDR_PAT_GATE);
  wire wr_sdf = reg_wr && (reg_addr == retimer_ctrl_pkg::ADDR_SD_FORCE);
  wire wr_div = reg_wr && (reg_addr == retimer_ctrl_pkg::ADDR_DIV_SEL);
  wire wr_cp = reg_wr && (reg_addr == retimer_ctrl_pkg::ADDR_CP_CTRL);
  wire wr_osel = reg_wr && (reg_addr == retimer_ctrl_pkg::ADDR_OUT_SEL);
  wire wr_cv = reg_wr && (reg_addr == retimer_ctrl_pkg::ADDR_CV_SET);
  wire wr_pcfg = reg_wr && (reg_addr == retimer_ctrl_pkg::ADDR_PAT_CFG);

  // RULE16: override register reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cap_q <= retimer_ctrl_pkg::RST_OTHER;
      ovr_q <= retimer_ctrl_pkg::RST_OVERRIDE;
      gate_q <= retimer_ctrl_pkg::RST_OTHER;
      sdf_q <= retimer_ctrl_pkg::RST_OTHER;
      div_q <= retimer_ctrl_pkg::RST_OTHER;
      cp_q <= retimer_ctrl_pkg::RST_OTHER;
      osel_q <= retimer_ctrl_pkg::RST_OUT_SEL;
      cv_q <= retimer_ctrl_pkg::RST_OTHER;
      pcfg_q <= retimer_ctrl_pkg::RST_OTHER;
    end else begin
      if (wr_cap) cap_q <= reg_wdata;
      if (wr_ovr) ovr_q <= reg_wdata;
      if (wr_gate) gate_q <= reg_wdata;
      if (wr_sdf) sdf_q <= reg_wdata;
      if (wr_div) div_q <= reg_wdata;
      if (wr_cp) cp_q <= reg_wdata;
      if (wr_osel) osel_q <= reg_wdata;
      if (wr_cv) cv_q <= reg_wdata;
      if (wr_pcfg) pcfg_q <= reg_wdata;
    end
  end

  logic [7:0] rd_mux_w;
  always_comb begin
    unique case (reg_addr)
      retimer_ctrl_pkg::ADDR_VCO_CAP: rd_mux_w = cap_q;
      retimer_ctrl_pkg::ADDR_OVERRIDE: rd_mux_w = ovr_q;
      retimer_ctrl_pkg::ADDR_PAT_GATE: rd_mux_w = gate_q;
      retimer_ctrl_pkg::ADDR_SD_FORCE: rd_mux_w = sdf_q;
      retimer_ctrl_pkg::ADDR_DIV_SEL: rd_mux_w = div_q;
      retimer_ctrl_pkg::ADDR_CP_CTRL: rd_mux_w = cp_q;
      retimer_ctrl_pkg::ADDR_OUT_SEL: rd_mux_w = osel_q;
      retimer_ctrl_pkg::ADDR_CV_SET: rd_mux_w = cv_q;
      retimer_ctrl_pkg::ADDR_PAT_CFG: rd_mux_w = pcfg_q;
      default: rd_mux_w = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) reg_rdata_q <= 8'h00;
    else if (reg_rd) reg_rdata_q <= rd_mux_w;
  end

  ////////////////////////////////////////////////////////////////////////////
  // divider choice and free-run controls
  wire [2:0] div_field_w = div_q[retimer_ctrl_pkg::DIV_LSB +: 3];
  // RULE1: override picks field
  wire [2:0] div_src_w = ov_w.div_ov ? div_field_w : rate_div_code;
  // invalid codes leave the ratio where it was rather than glitch the vco
  wire div_ok_w = (div_src_w <= retimer_ctrl_pkg::DIV_MAX_CODE);
  // RULE11: forced detect
  wire force_off_w = sdf_q[retimer_ctrl_pkg::SD_FORCE_OFF_BIT];
  wire force_on_w = sdf_q[retimer_ctrl_pkg::SD_FORCE_ON_BIT] && !force_off_w;
  wire chan_en_w = !force_off_w && (force_on_w || signal_present);
  // RULE12: pump disable
  wire cp_on_w = !(ov_w.cp_dis && (cp_q[1:0] == 2'h0));
  retimer_ctrl_pkg::vco_ctrl_t vco_d;
  assign vco_d.charge_pump_en = cp_on_w;
  // RULE13: cap count override
  assign vco_d.cap_override = ov_w.cap_ov;
  assign vco_d.cap_count = cap_q[4:0];
  // RULE14: control voltage override
  assign vco_d.cv_override = ov_w.cv_ov;
  assign vco_d.cv_value = cv_q[4:0];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_code_q <= 3'h0;
      div_ratio_q <= 5'h01;
      channel_enable_q <= 1'b0;
      vco_ctrl_q <= '0;
      vco_track_input_q <= 1'b0;
    end else begin
      // RULE3: automatic divider
      if (div_ok_w) begin
        div_code_q <= div_src_w;
        // RULE2: code to ratio
        div_ratio_q <= 5'(5'h01 << div_src_w);
      end
      channel_enable_q <= chan_en_w;
      vco_ctrl_q <= vco_d;
      // RULE10: lock ignores mux
      vco_track_input_q <= chan_en_w && cdr_locked && cp_on_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pattern generator sequence and shift register
  typedef enum logic [3:0] {
    PG_OFF = 4'b0001,
    PG_HELD = 4'b0010,
    PG_ARMED = 4'b0100,
    PG_RUN = 4'b1000
  } pg_state_t;
  pg_state_t pg_q, pg_d;
  logic [30:0] lfsr_q;

  wire pg_en_w = osel_q[retimer_ctrl_pkg::PAT_EN_BIT];
  wire pg_load_w = pcfg_q[retimer_ctrl_pkg::PAT_LOAD_BIT];
  wire pg_gate_w = gate_q[retimer_ctrl_pkg::PAT_GATE_BIT];
  wire [1:0] pg_sel_w = pcfg_q[1:0];
  wire sel9_w = (pg_sel_w == retimer_ctrl_pkg::PAT_SEL_9);
  wire sel31_w = (pg_sel_w == retimer_ctrl_pkg::PAT_SEL_31);
  // RULE21: feedback taps
  wire fb9_w = lfsr_q[8] ^ lfsr_q[4];
  wire fb31_w = lfsr_q[30] ^ lfsr_q[27];
  wire fb_w = sel9_w ? fb9_w : fb31_w;
  logic fifo_in_ready;
  // RULE4: only two legal selections
  wire pg_push_w = (pg_q == PG_RUN) && (sel9_w || sel31_w);
  wire pg_step_w = pg_push_w && fifo_in_ready;

  // RULE8: software start order
  always_comb begin
    pg_d = pg_q;
    unique case (pg_q)
      PG_OFF: if (pg_en_w) pg_d = pg_load_w ? PG_ARMED : PG_HELD;
      PG_HELD: if (pg_load_w) pg_d = PG_ARMED;
      PG_ARMED: if (!pg_load_w) pg_d = PG_HELD;
        else if (pg_gate_w) pg_d = PG_RUN;
      PG_RUN: if (!pg_load_w) pg_d = PG_HELD;
        else if (!pg_gate_w) pg_d = PG_ARMED;
    endcase
    // RULE5: enable dominates
    if (!pg_en_w) pg_d = PG_OFF;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) pg_q <= PG_OFF;
    else pg_q <= pg_d;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lfsr_q <= retimer_ctrl_pkg::PAT_SEED;
      pattern_running_q <= 1'b0;
    end else begin
      pattern_running_q <= (pg_d == PG_RUN);
      // RULE6: held at seed
      if (pg_q == PG_OFF || pg_q == PG_HELD) begin
        lfsr_q <= retimer_ctrl_pkg::PAT_SEED;
      // RULE7: gated advance
      end else if (pg_step_w) begin
        if (sel9_w) lfsr_q <= {lfsr_q[30:9], lfsr_q[7:0], fb9_w};
        else lfsr_q <= {lfsr_q[29:0], fb31_w};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pattern fifo, slow clock and output multiplexer
  wire [2:0] osel_w = osel_q[retimer_ctrl_pkg::OUT_SEL_LSB +: 3];
  // RULE20: unlocked default
  wire [2:0] eff_sel_w = (ov_w.mux_ov || !cdr_locked) ? osel_w :
    retimer_ctrl_pkg::MUX_RETIMED;
  // RULE9: pattern to line
  wire pat_sel_w = chan_en_w && (eff_sel_w == retimer_ctrl_pkg::MUX_PATTERN);
  logic fifo_out_valid;
  logic fifo_out_bit;
  wire fifo_pop_w = pat_sel_w && line_ready;

  bit_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_pat_fifo (
    .clk(core_clk),
    .rst(rst),
    .flush(pg_q != PG_RUN && pg_q != PG_ARMED),
    .in_valid(pg_push_w),
    .in_ready(fifo_in_ready),
    .in_data(fb_w),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop_w),
    .out_data(fifo_out_bit)
  );

  // slow clock is a divided enable toggle, so it never creates a clock domain
  logic [4:0] slow_cnt_q;
  logic slow_clk_q;
  wire slow_wrap_w = (slow_cnt_q == 5'(retimer_ctrl_pkg::SLOW_HALF_CYC - 1));
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slow_cnt_q <= 5'h00;
      slow_clk_q <= 1'b0;
    end else begin
      slow_cnt_q <= slow_wrap_w ? 5'h00 : slow_cnt_q + 5'h01;
      if (slow_wrap_w) slow_clk_q <= ~slow_clk_q;
    end
  end

  // RULE19: mux decode
  logic mux_bit_w;
  logic mux_mute_w;
  always_comb begin
    mux_bit_w = 1'b0;
    mux_mute_w = 1'b0;
    unique case (eff_sel_w)
      retimer_ctrl_pkg::MUX_RAW: mux_bit_w = raw_data_bit;
      retimer_ctrl_pkg::MUX_RETIMED: mux_bit_w = retimed_data_bit;
      retimer_ctrl_pkg::MUX_ICLK: mux_bit_w = vco_in_phase_clock;
      retimer_ctrl_pkg::MUX_QCLK: mux_bit_w = vco_quadrature_clock;
      retimer_ctrl_pkg::MUX_PATTERN: begin
        mux_bit_w = fifo_out_bit;
        mux_mute_w = !fifo_out_valid;
      end
      retimer_ctrl_pkg::MUX_SLOW_CLK: mux_bit_w = slow_clk_q;
      default: mux_mute_w = 1'b1;
    endcase
    if (!chan_en_w) mux_mute_w = 1'b1;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      line_bit_q <= 1'b0;
      line_mute_q <= 1'b1;
    end else begin
      line_bit_q <= mux_mute_w ? 1'b0 : mux_bit_w;
      line_mute_q <= mux_mute_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_div_override;
    @(posedge core_clk) disable iff (rst)
      ov_w.div_ov && div_field_w <= 3'h4 |=> div_code_q == $past(div_field_w);
  endproperty
  a_div_override: assert property (p_div_override) // RULE1
    else $error("divider did not follow override field");

  property p_div_ratio;
    @(posedge core_clk) disable iff (rst)
      (ov_w.div_ov && div_field_w == 3'h4) |=> (div_ratio_q == 5'h10);
  endproperty
  a_div_ratio: assert property (p_div_ratio) // RULE2
    else $error("code 4 did not give ratio 16");

  property p_div_auto;
    @(posedge core_clk) disable iff (rst)
      (!ov_w.div_ov && rate_div_code <= 3'h4) |=>
        (div_code_q == $past(rate_div_code));
  endproperty
  a_div_auto: assert property (p_div_auto) // RULE3
    else $error("automatic divider not followed");

  property p_prbs9;
    @(posedge core_clk) disable iff (rst)
      (pg_step_w && sel9_w) |=>
        lfsr_q[8:0] == {$past(lfsr_q[7:0]), $past(lfsr_q[8] ^ lfsr_q[4])};
  endproperty
  a_prbs9: assert property (p_prbs9) // RULE4
    else $error("9-stage step wrong");

  property p_en_off;
    @(posedge core_clk) disable iff (rst)
      !pg_en_w |=> (pg_q == PG_OFF) && !pattern_running_q;
  endproperty
  a_en_off: assert property (p_en_off) // RULE5
    else $error("generator active while disabled");

  property p_load_hold;
    @(posedge core_clk) disable iff (rst)
      !pg_load_w ##1 !pg_load_w |=> (lfsr_q == retimer_ctrl_pkg::PAT_SEED);
  endproperty
  a_load_hold: assert property (p_load_hold) // RULE6
    else $error("generator not held at seed");

  property p_gate;
    @(posedge core_clk) disable iff (rst)
      !pg_gate_w |=> !pattern_running_q && (pg_q != PG_RUN);
  endproperty
  a_gate: assert property (p_gate) // RULE7
    else $error("generator advanced with gate closed");

  property p_pattern_out;
    @(posedge core_clk) disable iff (rst)
      (pat_sel_w && fifo_out_valid) |=>
        (line_bit_q == $past(fifo_out_bit)) && !line_mute_q;
  endproperty
  a_pattern_out: assert property (p_pattern_out) // RULE9
    else $error("pattern not driven on line");

  property p_chan_en;
    @(posedge core_clk) disable iff (rst)
      (!signal_present && sdf_q[7:6] == 2'b10) |=> channel_enable_q;
  endproperty
  a_chan_en: assert property (p_chan_en) // RULE11
    else $error("forced detect did not enable channel");

  property p_pump;
    @(posedge core_clk) disable iff (rst)
      (ov_w.cp_dis && cp_q[1:0] == 2'h0) |=>
        !vco_ctrl_q.charge_pump_en && !vco_track_input_q;
  endproperty
  a_pump: assert property (p_pump) // RULE12
    else $error("charge pump still enabled");

  property p_clear_all;
    @(posedge core_clk) disable iff (rst)
      (wr_ovr && reg_wdata == 8'h00) ##1 !wr_ovr |=>
        !vco_ctrl_q.cap_override && !vco_ctrl_q.cv_override;
  endproperty
  a_clear_all: assert property (p_clear_all) // RULE16
    else $error("overrides not cleared");

  property p_unlock_mute;
    @(posedge core_clk) disable iff (rst)
      (!ov_w.mux_ov && !cdr_locked && osel_w == 3'h7) |=> line_mute_q;
  endproperty
  a_unlock_mute: assert property (p_unlock_mute) // RULE20
    else $error("unlocked output not muted");

  c_pattern_run: cover property (@(posedge core_clk) disable iff (rst)
    pattern_running_q && pat_sel_w ##1 !line_mute_q);
  c_fifo_full: cover property (@(posedge core_clk) disable iff (rst)
    pg_push_w && !fifo_in_ready);
  c_free_run: cover property (@(posedge core_clk) disable iff (rst)
    ovr_q[7:2] == 6'h3f);
endmodule
`default_nettype wire

//--- sim/line_sink.sv
// line receiver model: takes one line bit per ready cycle
// assumes the bit shows one cycle after the taking edge
`timescale 1ns/10ps
`default_nettype none
module line_sink (
  input wire logic core_clk,
  input wire logic line_bit_q,
  input wire logic line_mute_q,
  input wire logic stall_en,
  output logic line_ready
);
  logic took;
  logic [1:0] ph;
  logic got[$];
  initial begin
    took = 1'b0;
    ph = 2'h0;
    line_ready = 1'b1;
  end
  always @(posedge core_clk) begin
    if (took && !line_mute_q) begin
      got.push_back(line_bit_q);
    end
    took <= line_ready;
  end
  // slow answer: ready drops one cycle in three
  always @(negedge core_clk) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    line_ready <= !(stall_en && ph == 2'h2);
  end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench of one retimer channel control block
// assumes the line receiver model of line_sink.sv on the line side
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic core_clk, rst, reg_wr, reg_rd, stall_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
  logic signal_present, cdr_locked, line_ready;
  logic [3:0] srcs;
  logic [2:0] rate_div_code, div_code_q;
  logic [4:0] div_ratio_q;
  logic line_bit_q, line_mute_q, channel_enable_q;
  logic vco_track_input_q, pattern_running_q;
  retimer_ctrl_pkg::vco_ctrl_t vc;
  int error_cnt, compares;
  localparam logic [7:0] MAP [10] = '{8'h08, 8'h09, 8'h0d, 8'h14,
    8'h18, 8'h1b, 8'h1e, 8'h1f, 8'h30, 8'h20};

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  retimer_prbs_and_vco_override_ctrl uut (
    .core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .signal_present(signal_present),
    .cdr_locked(cdr_locked), .rate_div_code(rate_div_code),
    .raw_data_bit(srcs[0]), .retimed_data_bit(srcs[1]),
    .vco_in_phase_clock(srcs[2]), .vco_quadrature_clock(srcs[3]),
    .line_ready(line_ready), .line_bit_q(line_bit_q),
    .line_mute_q(line_mute_q), .channel_enable_q(channel_enable_q),
    .vco_track_input_q(vco_track_input_q), .div_code_q(div_code_q),
    .div_ratio_q(div_ratio_q), .vco_ctrl_q(vc),
    .pattern_running_q(pattern_running_q));

  line_sink u_sink (.core_clk(core_clk), .line_bit_q(line_bit_q),
    .line_mute_q(line_mute_q), .stall_en(stall_en),
    .line_ready(line_ready));

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
      input string m);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // derived outputs lag the register by one to three edges, so settle three
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
    cyc(3);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk(reg_rdata_q, e, "read data");
  endtask

  task automatic do_reset();
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 10; i++) begin
      rd(MAP[i], (i == 6) ? 8'he0 : 8'h00);
    end
    chk(line_mute_q, 1'b1, "reset mute");
    chk(div_ratio_q, 5'h01, "reset ratio");
    for (int i = 0; i < 10; i++) begin
      wr(MAP[i], 8'h5a);
      rd(MAP[i], (i == 9) ? 8'h00 : 8'h5a);
    end
    do_reset();
    rd(8'h09, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_div();
    // override used here to step the ratios, then to hold ratio 16 against field code 5 and rate code 3
    wr(8'h09, 8'h04);
    for (int c = 0; c < 5; c++) begin
      wr(8'h18, 8'(c << 4));
      chk(div_ratio_q, 32'd1 << c, "div ratio");
      chk(div_code_q, c, "div code");
    end
    wr(8'h18, 8'h50);
    rate_div_code = 3'h3;
    cyc(3);
    chk(div_ratio_q, 5'h10, "bad code or auto leak");
    wr(8'h09, 8'h00);
    chk(div_ratio_q, 5'h08, "auto ratio");
    $display("test divider done");
  endtask

  task automatic t_free();
    signal_present = 1'b0;
    cdr_locked = 1'b0;
    cyc(3);
    chk(channel_enable_q, 1'b0, "no signal");
    wr(8'h14, 8'h80);
    chk(channel_enable_q, 1'b1, "forced on");
    // each write keeps earlier override bits
    wr(8'h09, 8'h08);
    wr(8'h1b, 8'h00);
    chk(vc.charge_pump_en, 1'b0, "pump off");
    wr(8'h09, 8'h0c);
    wr(8'h18, 8'h00);
    chk(div_ratio_q, 5'h01, "free ratio");
    wr(8'h09, 8'h8c);
    wr(8'h08, 8'h08);
    chk({vc.cap_override, vc.cap_count}, 6'h28, "cap");
    wr(8'h09, 8'hcc);
    wr(8'h1f, 8'h12);
    chk({vc.cv_override, vc.cv_value}, 6'h32, "volt");
    chk(vc.charge_pump_en, 1'b0, "pump kept off");
    rd(8'h09, 8'hcc);
    wr(8'h09, 8'h00);
    chk({vc.charge_pump_en, vc.cap_override, vc.cv_override}, 3'h4,
      "overrides cleared");
    chk(div_ratio_q, 5'h08, "auto again");
    $display("test free run done");
  endtask

  task automatic t_prbs(input logic [1:0] sel, input int l, input int t);
    int w;
    wr(8'h1e, 8'he0);
    wr(8'h30, {6'h00, sel});
    wr(8'h30, {6'h02, sel});
    wr(8'h0d, 8'h20);
    chk(pattern_running_q, 1'b0, "disabled");
    wr(8'h0d, 8'h00);
    // enable, clear load, select, load, clock
    wr(8'h1e, 8'hf0);
    wr(8'h30, {6'h00, sel});
    chk(pattern_running_q, 1'b0, "held");
    wr(8'h30, {6'h02, sel});
    chk(pattern_running_q, 1'b0, "no clock");
    wr(8'h0d, 8'h20);
    chk(pattern_running_q, 1'b1, "running");
    wr(8'h09, 8'h20);
    u_sink.got.delete();
    wr(8'h1e, 8'h90);
    w = 0;
    while (u_sink.got.size() < 80 && w < 3000) begin
      cyc(1);
      w++;
    end
    chk(w < 3000, 1'b1, "bits arrive");
    chk(u_sink.got[0], 1'b0, "first bit");
    for (int n = l; n < 80; n++) begin
      chk(u_sink.got[n], u_sink.got[n-l] ^ u_sink.got[n-t], "seq");
    end
    wr(8'h30, {6'h00, sel});
    chk(pattern_running_q, 1'b0, "load cleared");
    $display("test pattern %0d done", l);
  endtask

  task automatic t_mux();
    logic b;
    wr(8'h14, 8'h00);
    signal_present = 1'b1;
    cdr_locked = 1'b1;
    wr(8'h14, 8'h40);
    chk({channel_enable_q, vco_track_input_q}, 2'h0, "forced off");
    wr(8'h14, 8'h00);
    wr(8'h09, 8'h30);
    for (int p = 0; p < 2; p++) begin
      srcs = p ? 4'ha : 4'h5;
      for (int c = 0; c < 4; c++) begin
        wr(8'h1e, {c[2:0], 5'h01});
        chk({line_mute_q, line_bit_q}, {1'b0, srcs[c]}, "src");
        chk(vco_track_input_q, 1'b1, "vco lock");
      end
    end
    wr(8'h1e, 8'he1);
    chk(line_mute_q, 1'b1, "mute code");
    wr(8'h1e, 8'hc1);
    chk(line_mute_q, 1'b1, "code 6 mute");
    wr(8'h1e, 8'ha1);
    b = line_bit_q;
    cyc(10);
    chk(line_bit_q, !b, "slow clock");
    wr(8'h09, 8'h00);
    wr(8'h1e, 8'he0);
    cdr_locked = 1'b0;
    cyc(3);
    chk(line_mute_q, 1'b1, "unlocked mute");
    cdr_locked = 1'b1;
    cyc(3);
    chk({line_mute_q, line_bit_q}, {1'b0, srcs[1]}, "locked");
    $display("test mux done");
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    #150us;
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    close_out();
  end

  initial begin
    error_cnt = 0;
    compares = 0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0_0000;
    {signal_present, cdr_locked, stall_en} = 3'h0;
    srcs = 4'h0;
    rate_div_code = 3'h0;
    do_reset();
    t_reset();
    t_div();
    t_free();
    t_prbs(2'h0, 9, 5);
    stall_en = 1'b1;
    t_prbs(2'h2, 31, 28);
    stall_en = 1'b0;
    t_mux();
    close_out();
  end
endmodule
`default_nettype wire
